// ---- sfc_consts.svh ----
// Purpose: named constants of the supervisory flash call dispatcher
// Assumes: included by bare name from every file that needs a figure
// Notes: definitions only, no logic
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
// memory geometry
`define SFC_RAM_BYTES 256
`define SFC_BLK_BYTES 64
`define SFC_BLK_SHIFT 6
`define SFC_AUX_ROWS 4
`define SFC_RAM_IDX_MSB 9
`define SFC_RAM_IDX_LSB 2
// auxiliary rows: protection, calibration, table
`define SFC_AUX_PROT 2'h0
`define SFC_AUX_CAL 2'h1
`define SFC_AUX_TABLE 2'h2
`define SFC_CAL_LAST 6'h3D
`define SFC_CAL_SUMHI 6'h3E
// parameter block in data ram page 0
`define SFC_P_FIRST_KEY_BYTE 8'hF8
`define SFC_P_SECOND_KEY_BYTE 8'hF9
`define SFC_P_BLK 8'hFA
`define SFC_P_PTR 8'hFB
`define SFC_P_CLK 8'hFC
`define SFC_P_MODE 8'hFD
`define SFC_P_DLY 8'hFE
`define SFC_P_PCL 8'hFF
// key values
`define SFC_FIRST_KEY_BYTE_VAL 8'h3A
`define SFC_SP_OFFSET 8'h03
// service codes
`define SFC_FN_BOOT 8'h00
`define SFC_FN_READ 8'h01
`define SFC_FN_WRITE 8'h02
`define SFC_FN_ERASE 8'h03
`define SFC_FN_ALL 8'h05
`define SFC_FN_TABLE 8'h06
`define SFC_FN_SUM 8'h07
// return codes
`define SFC_RC_OK 8'h00
`define SFC_RC_PROT 8'h01
`define SFC_RC_SWRST 8'h02
`define SFC_RC_FATAL 8'h03
// flash byte values, protection modes and erase phases
`define SFC_ERASED 8'hFF
`define SFC_ZERO 8'h00
`define SFC_MODE_RDPROT 2'h1
`define SFC_MODE_WRPROT 2'h3
`define SFC_PH_ZERO 2'h1
`define SFC_PH_LAST 2'h2
// apb map
`define SFC_A_RAM_TOP 12'h3FC
`define SFC_A_STATUS 12'h400
`define SFC_A_FADDR 12'h404
`define SFC_A_FDATA 12'h408
`define SFC_A_CALL 12'h40C
`define SFC_CALL_USER 16
`endif

// ---- sfc_pkg.sv ----
// Purpose: shared types of the supervisory flash call dispatcher
// Assumes: nothing
// Notes: state codes are one-hot
package sfc_pkg;
	// dispatcher states
	typedef enum logic [10:0] {
		ST_IDLE = 11'h001,
		ST_BOOT = 11'h002,
		ST_CHECK = 11'h004,
		ST_READ = 11'h008,
		ST_WRITE = 11'h010,
		ST_ERASE = 11'h020,
		ST_ALL = 11'h040,
		ST_PROT = 11'h080,
		ST_SUM = 11'h100,
		ST_DONE = 11'h200,
		ST_HALT = 11'h400
	} sfc_state_t;
endpackage

// ---- sfc_flash_array.sv ----
// Purpose: flip-flop model of the flash user blocks plus auxiliary rows
// Assumes: one byte written per cycle, reads combinational from storage
// Notes: aux rows sit directly above the user blocks
`include "sfc_consts.svh"
module sfc_flash_array #(
	parameter int NBLK = 128
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// byte write port
	input wire logic wrEn,
	input wire logic [$clog2((NBLK + `SFC_AUX_ROWS) * `SFC_BLK_BYTES)-1:0] wrAddr,
	input wire logic [7:0] wrData,
	// two read ports: data and protection
	input wire logic [$clog2((NBLK + `SFC_AUX_ROWS) * `SFC_BLK_BYTES)-1:0] rdAddrA,
	output logic [7:0] rdDataA,
	input wire logic [$clog2((NBLK + `SFC_AUX_ROWS) * `SFC_BLK_BYTES)-1:0] rdAddrB,
	output logic [7:0] rdDataB
);
	import sfc_pkg::*;
	localparam int NBYTES = (NBLK + `SFC_AUX_ROWS) * `SFC_BLK_BYTES;

	// whole state of the array
	typedef struct packed {
		logic [NBYTES-1:0][7:0] mem;
	} sfc_flash_t;

	sfc_flash_t s_r;
	sfc_flash_t s_nxt;

	// next state: one byte written when asked
	always_comb
	begin
		s_nxt = s_r;
		if (wrEn)
		begin
			s_nxt.mem[wrAddr] = wrData;
		end
	end

	// storage; cleared at reset so every block starts unprotected
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_r <= '0;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// reads straight from the flops
	assign rdDataA = s_r.mem[rdAddrA];
	assign rdDataB = s_r.mem[rdAddrB];
endmodule // sfc_flash_array

// ---- sfc_dispatch.sv ----
// Purpose: supervisory call dispatcher running flash services for the core
// Assumes: core is the apb master; fetchInRom comes from core logic on clk
// Notes: one byte of flash or ram moves per cycle; pready is always high
// Notes on behaviour
// - data ram of 256 bytes holds parameters
// - flash registers only reachable from supervisory space
// - four aux rows; whole erase touches only the protection row
// - serial programming path may also queue calls (not here: a call while busy gets a bus error)
// - call opcode enters the supervisory service
// - accumulator selects the service code
// - undefined code from user code halts
// - parameter block at ram F8h to FFh
// - first key must be 3Ah
// - second key equals stack pointer plus three
// - key mismatch halts, except boot reset (here an undefined serial-path code returns fatal instead)
// - return code written to first key byte
// - checksum and table read return data instead
// - codes: ok, protected, soft reset, fatal
// - protected blocks refuse read, write, erase
// - whole erase: erase, zero, erase each macro
// - then protection block erased and zeroed
// - block services act on 64 bytes
// - refusal clears accumulator and second key
//
// Our own choices: the address map and register access over APB.
`include "sfc_consts.svh"
module sfc_dispatch #(
	parameter int NBLK = 128
) (
	// clock and reset
	input wire logic clk,
	input wire logic nrst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	input wire logic fetchInRom,
	output logic svcBusy,
	output logic cpuHalt,
	output logic retValid,
	output logic [7:0] retAcc,
	output logic [7:0] retSp,
	output sfc_pkg::sfc_state_t svcState
);
	import sfc_pkg::*;
	localparam int FBYTES = (NBLK + `SFC_AUX_ROWS) * `SFC_BLK_BYTES;
	localparam int FAW = $clog2(FBYTES);
	localparam logic [FAW-1:0] USER_END = FAW'(NBLK * `SFC_BLK_BYTES - 1);
	localparam logic [FAW-1:0] AUX_BASE = FAW'(NBLK * `SFC_BLK_BYTES);

	// whole state of the dispatcher
	typedef struct packed {
		sfc_state_t st; // current service step
		logic [`SFC_RAM_BYTES-1:0][7:0] ram; // data ram with parameter block
		logic [7:0] fn; // service code from the call
		logic [7:0] sp; // stack pointer at call
		logic fromUser; // call issued from user code
		logic swBoot; // boot reset asked by software
		logic wrCode; // done writes a return code
		logic bootOk; // calibration checksum matched
		logic retValid; // return pulse
		logic [FAW-1:0] cnt; // byte counter
		logic [1:0] phase; // erase-all sub step
		logic [15:0] sum; // running checksum
		logic [7:0] retCode; // code for first key byte
		logic [7:0] retAcc; // accumulator handed back
		logic [7:0] retSp; // stack pointer handed back
		logic [FAW-1:0] fAddr; // direct flash address register
		logic [31:0] prdata; // apb read data
		logic slvErr; // apb error for the access phase
	} sfc_dsp_t;

	sfc_dsp_t s_r;
	sfc_dsp_t s_nxt;

	// flash ports
	logic fWe;
	logic [FAW-1:0] fWrAddr;
	logic [7:0] fWrData;
	logic [FAW-1:0] fRdAddr;
	logic [7:0] fRdData;
	logic [FAW-1:0] pRdAddr;
	logic [7:0] pRdData;

	// parameter block fields and derived values
	logic [7:0] blk;
	logic [7:0] ptr;
	logic [FAW-1:0] blkBase;
	logic [FAW-1:0] curAddr;
	logic [7:0] ramIdx;
	logic lastByte;
	logic [1:0] protMode;
	logic fnKnown;
	logic keyOk;
	logic blkOk;
	logic readRefused;
	logic writeRefused;
	logic [15:0] sumAdd;

	// apb decode
	logic setup;
	logic access;
	logic wrOk;
	logic ramHit;
	logic flashReg;
	logic flashOk;
	logic [7:0] apbIdx;
	logic callTake;

	sfc_flash_array #(
		.NBLK(NBLK)
	) uFlash (
		.clk(clk),
		.nrst(nrst),
		.wrEn(fWe),
		.wrAddr(fWrAddr),
		.wrData(fWrData),
		.rdAddrA(fRdAddr),
		.rdDataA(fRdData),
		.rdAddrB(pRdAddr),
		.rdDataB(pRdData)
	);

	// parameter block lives at the top of page 0
	assign blk = s_r.ram[`SFC_P_BLK];
	assign ptr = s_r.ram[`SFC_P_PTR];
	assign blkBase = FAW'(blk) << `SFC_BLK_SHIFT;
	assign curAddr = blkBase + s_r.cnt;
	assign ramIdx = ptr + 8'(s_r.cnt[`SFC_BLK_SHIFT-1:0]);
	assign lastByte = &s_r.cnt[`SFC_BLK_SHIFT-1:0];
	// four blocks per protection byte, lowest block in lowest bits
	assign pRdAddr = AUX_BASE + FAW'(blk[7:2]);
	assign protMode = 2'(pRdData >> {blk[1:0], 1'b0});
	assign readRefused = (protMode == `SFC_MODE_RDPROT);
	assign writeRefused = (protMode == `SFC_MODE_WRPROT);
	assign blkOk = (32'(blk) < NBLK);
	assign sumAdd = s_r.sum + 16'(fRdData);

	// service code and keys
	always_comb
	begin
		case (s_r.fn)
			`SFC_FN_READ, `SFC_FN_WRITE, `SFC_FN_ERASE, `SFC_FN_ALL,
			`SFC_FN_TABLE, `SFC_FN_SUM: fnKnown = 1'b1;
			default: fnKnown = 1'b0;
		endcase
	end
	assign keyOk = (s_r.ram[`SFC_P_FIRST_KEY_BYTE] == `SFC_FIRST_KEY_BYTE_VAL) &&
		(s_r.ram[`SFC_P_SECOND_KEY_BYTE] == s_r.sp + `SFC_SP_OFFSET);

	// apb decode; errors decided in setup, shown in access
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign wrOk = access && pwrite && !s_r.slvErr;
	assign ramHit = (paddr <= `SFC_A_RAM_TOP);
	assign apbIdx = paddr[`SFC_RAM_IDX_MSB:`SFC_RAM_IDX_LSB];
	assign flashReg = (paddr == `SFC_A_FADDR) || (paddr == `SFC_A_FDATA);
	// flash registers only while the core fetches from supervisory space
	assign flashOk = fetchInRom && (s_r.st == ST_IDLE);
	assign callTake = wrOk && (paddr == `SFC_A_CALL) && (s_r.st == ST_IDLE);

	// flash port steering: services own it, apb only when idle
	always_comb
	begin
		fWe = 1'b0;
		fWrAddr = curAddr;
		fWrData = `SFC_ERASED;
		fRdAddr = s_r.fAddr;
		case (s_r.st)
			ST_IDLE:
			begin
				fWe = wrOk && (paddr == `SFC_A_FDATA);
				fWrAddr = s_r.fAddr;
				fWrData = pwdata[7:0];
			end
			ST_BOOT: fRdAddr = AUX_BASE + {FAW'(`SFC_AUX_CAL) << `SFC_BLK_SHIFT} + s_r.cnt;
			ST_CHECK: fRdAddr = AUX_BASE + FAW'({`SFC_AUX_TABLE, blk[5:0]});
			ST_READ: fRdAddr = curAddr;
			ST_SUM: fRdAddr = s_r.cnt;
			ST_WRITE:
			begin
				fWe = 1'b1;
				fWrData = s_r.ram[ramIdx];
			end
			ST_ERASE: fWe = 1'b1;
			ST_ALL:
			begin
				// erase, program zeros, erase each user byte
				fWe = 1'b1;
				fWrAddr = s_r.cnt;
				fWrData = (s_r.phase == `SFC_PH_ZERO) ? `SFC_ZERO : `SFC_ERASED;
			end
			ST_PROT:
			begin
				// protection row only; other aux rows are never addressed
				fWe = 1'b1;
				fWrAddr = AUX_BASE + s_r.cnt;
				fWrData = (s_r.phase == `SFC_PH_ZERO) ? `SFC_ZERO : `SFC_ERASED;
			end
			default: fWe = 1'b0;
		endcase
	end

	// next state of everything
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.retValid = 1'b0;
		// apb setup phase: latch read data and error
		if (setup)
		begin
			s_nxt.slvErr = 1'b0;
			s_nxt.prdata = '0;
			if (ramHit)
			begin
				s_nxt.prdata = {24'h000000, s_r.ram[apbIdx]};
				s_nxt.slvErr = pwrite && (s_r.st != ST_IDLE);
			end
			else if (paddr == `SFC_A_STATUS)
			begin
				s_nxt.prdata = {16'h0000, s_r.retAcc, 5'h00, s_r.bootOk, cpuHalt, svcBusy};
			end
			else if (flashReg)
			begin
				s_nxt.slvErr = !flashOk;
				s_nxt.prdata = (paddr == `SFC_A_FADDR) ? 32'(s_r.fAddr) : {24'h000000, fRdData};
			end
			else if (paddr == `SFC_A_CALL)
			begin
				s_nxt.slvErr = pwrite && (s_r.st != ST_IDLE);
			end
			else
			begin
				s_nxt.slvErr = 1'b1;
			end
		end
		// apb writes that land in storage
		if (wrOk && ramHit)
		begin
			s_nxt.ram[apbIdx] = pwdata[7:0];
		end
		if (wrOk && (paddr == `SFC_A_FADDR))
		begin
			s_nxt.fAddr = FAW'(pwdata);
		end
		case (s_r.st)
			ST_IDLE:
			begin
				// a call register write stands for the call opcode
				if (callTake)
				begin
					s_nxt.fn = pwdata[7:0];
					s_nxt.sp = pwdata[15:8];
					s_nxt.fromUser = pwdata[`SFC_CALL_USER];
					s_nxt.st = ST_CHECK;
				end
			end
			ST_BOOT:
			begin
				// calibration row sum, stored high byte then low byte
				if (s_r.cnt[`SFC_BLK_SHIFT-1:0] <= `SFC_CAL_LAST)
				begin
					s_nxt.sum = sumAdd;
				end
				else if (s_r.cnt[`SFC_BLK_SHIFT-1:0] == `SFC_CAL_SUMHI)
				begin
					s_nxt.bootOk = (fRdData == s_r.sum[15:8]);
				end
				else
				begin
					s_nxt.bootOk = s_r.bootOk && (fRdData == s_r.sum[7:0]);
				end
				s_nxt.cnt = s_r.cnt + FAW'(1);
				if (lastByte)
				begin
					s_nxt.cnt = '0;
					s_nxt.retCode = `SFC_RC_SWRST;
					s_nxt.wrCode = 1'b1;
					s_nxt.st = s_r.swBoot ? ST_DONE : ST_IDLE;
				end
			end
			ST_CHECK:
			begin
				s_nxt.cnt = '0;
				s_nxt.sum = '0;
				s_nxt.phase = '0;
				s_nxt.wrCode = 1'b1;
				s_nxt.retCode = `SFC_RC_OK;
				s_nxt.st = ST_DONE;
				if (s_r.fn == `SFC_FN_BOOT)
				begin
					// boot reset ignores keys and parameters
					s_nxt.swBoot = 1'b1;
					s_nxt.bootOk = 1'b0;
					s_nxt.st = ST_BOOT;
				end
				else if (!fnKnown)
				begin
					// an undefined serial-path code is not halted, it gets a fatal code
					s_nxt.retCode = `SFC_RC_FATAL;
					s_nxt.st = s_r.fromUser ? ST_HALT : ST_DONE;
				end
				else if (!keyOk)
				begin
					s_nxt.st = ST_HALT;
				end
				else if (s_r.fn == `SFC_FN_ALL)
				begin
					s_nxt.st = ST_ALL;
				end
				else if (s_r.fn == `SFC_FN_TABLE)
				begin
					s_nxt.ram[`SFC_P_FIRST_KEY_BYTE] = fRdData;
					s_nxt.wrCode = 1'b0;
				end
				else if (!blkOk)
				begin
					s_nxt.retCode = `SFC_RC_FATAL;
				end
				else if (s_r.fn == `SFC_FN_SUM)
				begin
					s_nxt.st = ST_SUM;
				end
				else if ((s_r.fn == `SFC_FN_READ) ? readRefused : writeRefused)
				begin
					s_nxt.retCode = `SFC_RC_PROT;
				end
				else
				begin
					case (s_r.fn)
						`SFC_FN_READ: s_nxt.st = ST_READ;
						`SFC_FN_WRITE: s_nxt.st = ST_WRITE;
						default: s_nxt.st = ST_ERASE;
					endcase
				end
			end
			ST_READ, ST_WRITE, ST_ERASE:
			begin
				if (s_r.st == ST_READ)
				begin
					s_nxt.ram[ramIdx] = fRdData;
				end
				s_nxt.cnt = s_r.cnt + FAW'(1);
				if (lastByte)
				begin
					s_nxt.st = ST_DONE;
				end
			end
			ST_ALL:
			begin
				s_nxt.phase = s_r.phase + 2'h1;
				if (s_r.phase == `SFC_PH_LAST)
				begin
					s_nxt.phase = '0;
					s_nxt.cnt = s_r.cnt + FAW'(1);
					if (s_r.cnt == USER_END)
					begin
						s_nxt.cnt = '0;
						s_nxt.st = ST_PROT;
					end
				end
			end
			ST_PROT:
			begin
				// each byte: erase, then program zero
				s_nxt.phase = s_r.phase + 2'h1;
				if (s_r.phase == `SFC_PH_ZERO)
				begin
					s_nxt.phase = '0;
					s_nxt.cnt = s_r.cnt + FAW'(1);
					if (lastByte)
					begin
						s_nxt.st = ST_DONE;
					end
				end
			end
			ST_SUM:
			begin
				// sums blocks 0 up to and including the given block
				s_nxt.sum = sumAdd;
				s_nxt.cnt = s_r.cnt + FAW'(1);
				if (lastByte && ((s_r.cnt >> `SFC_BLK_SHIFT) == FAW'(blk)))
				begin
					s_nxt.ram[`SFC_P_FIRST_KEY_BYTE] = sumAdd[7:0];
					s_nxt.ram[`SFC_P_SECOND_KEY_BYTE] = sumAdd[15:8];
					s_nxt.wrCode = 1'b0;
					s_nxt.st = ST_DONE;
				end
			end
			ST_DONE:
			begin
				if (s_r.wrCode)
				begin
					s_nxt.ram[`SFC_P_FIRST_KEY_BYTE] = s_r.retCode;
				end
				// ok and refusal leave accumulator and second key cleared
				s_nxt.retAcc = s_r.fn;
				if (s_r.wrCode && (s_r.retCode <= `SFC_RC_PROT))
				begin
					s_nxt.ram[`SFC_P_SECOND_KEY_BYTE] = `SFC_ZERO;
					s_nxt.retAcc = `SFC_ZERO;
				end
				s_nxt.retSp = s_r.sp;
				s_nxt.retValid = 1'b1;
				s_nxt.swBoot = 1'b0;
				s_nxt.st = ST_IDLE;
			end
			ST_HALT: s_nxt.st = ST_HALT;
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	// state register; hardware reset enters boot reset
	always_ff @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_r <= '0;
			s_r.st <= ST_BOOT;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// outputs
	assign prdata = s_r.prdata;
	assign pready = 1'b1;
	assign pslverr = access && s_r.slvErr;
	assign svcBusy = (s_r.st != ST_IDLE) && (s_r.st != ST_HALT);
	assign cpuHalt = (s_r.st == ST_HALT);
	assign retValid = s_r.retValid;
	assign retAcc = s_r.retAcc;
	assign retSp = s_r.retSp;
	assign svcState = s_r.st;

	// checks
	property p_callStart;
		@(posedge clk) disable iff (!nrst)
		callTake |=> (s_r.st == ST_CHECK) ##1 (s_r.st != ST_IDLE);
	endproperty
	a_callStart: assert property (p_callStart) else $error("call not started");

	property p_keyHalt;
		@(posedge clk) disable iff (!nrst)
		(s_r.st == ST_CHECK && fnKnown && !keyOk) |=> cpuHalt ##1 cpuHalt;
	endproperty
	a_keyHalt: assert property (p_keyHalt) else $error("bad key did not halt");

	property p_undefHalt;
		@(posedge clk) disable iff (!nrst)
		(s_r.st == ST_CHECK && !fnKnown && s_r.fn != `SFC_FN_BOOT && s_r.fromUser)
			|=> cpuHalt && !svcBusy;
	endproperty
	a_undefHalt: assert property (p_undefHalt) else $error("undefined code ran");

	property p_refuse;
		@(posedge clk) disable iff (!nrst)
		(s_r.st == ST_CHECK && s_r.fn == `SFC_FN_READ && keyOk && blkOk && readRefused)
			|=> ##1 (s_r.ram[`SFC_P_FIRST_KEY_BYTE] == `SFC_RC_PROT && s_r.ram[`SFC_P_SECOND_KEY_BYTE] == `SFC_ZERO
			&& retValid && retAcc == `SFC_ZERO);
	endproperty
	a_refuse: assert property (p_refuse) else $error("refusal not reported");

	property p_romGate;
		@(posedge clk) disable iff (!nrst)
		(setup && flashReg && !fetchInRom) |=> pslverr;
	endproperty
	a_romGate: assert property (p_romGate) else $error("flash register open to user");

	property p_readLen;
		@(posedge clk) disable iff (!nrst)
		$rose(s_r.st == ST_READ) |-> ##63 (s_r.st == ST_READ) ##1 (s_r.st == ST_DONE);
	endproperty
	a_readLen: assert property (p_readLen) else $error("block read not 64 bytes");

	property p_auxSafe;
		@(posedge clk) disable iff (!nrst)
		(s_r.st == ST_ALL) |-> fWe && fWrAddr <= USER_END;
	endproperty
	a_auxSafe: assert property (p_auxSafe) else $error("whole erase hit aux row");

	property p_retSp;
		@(posedge clk) disable iff (!nrst)
		retValid |-> retSp == s_r.sp && $past(s_r.st) == ST_DONE;
	endproperty
	a_retSp: assert property (p_retSp) else $error("stack pointer not restored");

	// a checksum refused for a block out of range carries a fatal code instead
	property p_sumData;
		@(posedge clk) disable iff (!nrst)
		(s_r.st == ST_DONE && s_r.fn == `SFC_FN_SUM && !s_r.wrCode)
			|=> s_r.ram[`SFC_P_FIRST_KEY_BYTE] == $past(s_r.sum[7:0]);
	endproperty
	a_sumData: assert property (p_sumData) else $error("checksum overwritten");

	c_read: cover property (@(posedge clk) disable iff (!nrst)
		(s_r.st == ST_READ) ##1 (s_r.st == ST_DONE));
	c_whole_array_erase_service: cover property (@(posedge clk) disable iff (!nrst)
		(s_r.st == ST_ALL) ##1 (s_r.st == ST_PROT));
	c_halt: cover property (@(posedge clk) disable iff (!nrst) $rose(cpuHalt));
endmodule // sfc_dispatch

// ---- sfc_core_model.sv ----
// Purpose: core model that drives apb and issues supervisory calls
// Assumes: tasks are entered right after a rising clock edge
// Notes: an idle cycle between transfers, so no signal changes twice in a step
module sfc_core_model #(
	parameter logic [7:0] LOADER_BLK = 8'h00
) (
	// clock
	input wire logic clk,
	// apb master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [11:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// fetch space of the core
	output logic fetchInRom
);
	timeunit 1ns;
	timeprecision 1ps;
	// free stack that each service code needs
	logic [7:0] stackNeed [8] = '{8'h00, 8'h07, 8'h0A, 8'h09, 8'h00, 8'h0B, 8'h03, 8'h03};
	// bus idle from time zero
	initial
	begin
		{psel, penable, pwrite, paddr, pwdata, fetchInRom} = '0;
	end
	// fetch space only moves between transfers
	task automatic rom(input logic v);
		@(posedge clk);
		fetchInRom <= v;
	endtask
	// one transfer; the request stands until pready is high at an edge
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// keys and parameters go in first, the call word last
	task automatic svc(input logic [7:0] code, sp, blk, ptr, input logic user, bad);
		logic [31:0] q;
		logic e;
		// firmware never writes or block-erases its own loader block
		if (code inside {8'h02, 8'h03} && blk == LOADER_BLK)
			return;
		// stack must not run into the parameter block
		if (sp + stackNeed[code[2:0]] > 8'hF7)
			return;
		xfer(1'b1, 12'h3E0, {24'h0, bad ? 8'h3B : 8'h3A}, q, e);
		xfer(1'b1, 12'h3E4, {24'h0, sp + 8'h03}, q, e);
		xfer(1'b1, 12'h3E8, {24'h0, blk}, q, e);
		xfer(1'b1, 12'h3EC, {24'h0, ptr}, q, e);
		xfer(1'b1, 12'h40C, {15'h0, user, sp, code}, q, e);
	endtask
endmodule // sfc_core_model

// ---- tb_supervisory_flash_call.sv ----
// Purpose: self-checking bench of the supervisory call dispatcher
// Assumes: four user blocks keep the whole erase short
// Notes: flash and ram clear on reset, so the halting cases run last
module tb_supervisory_flash_call;
	timeunit 1ns;
	timeprecision 1ps;
	import sfc_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic psel, penable, pwrite, pready, pslverr, fetchInRom;
	logic svcBusy, cpuHalt, retValid;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] retAcc, retSp;
	sfc_state_t svcState;
	int fails = 0;
	int samplesChecked = 0;
	always #4 clk = ~clk;
	sfc_dispatch #(.NBLK(4)) dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fetchInRom(fetchInRom), .svcBusy(svcBusy), .cpuHalt(cpuHalt),
		.retValid(retValid), .retAcc(retAcc), .retSp(retSp), .svcState(svcState));
	sfc_core_model core (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fetchInRom(fetchInRom));
	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samplesChecked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	// one bus transfer, error flag judged every time
	task automatic ax(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
		logic e;
		core.xfer(w, a, d, q, e);
		chk(e, ee, "bus error flag");
	endtask
	task automatic ramIs(input logic [7:0] i, input logic [7:0] v);
		ax(1'b0, {2'b00, i, 2'b00}, 32'h0, 1'b0);
		chk(q, {24'h0, v}, "ram byte");
	endtask
	task automatic fput(input logic [11:0] a, input logic [7:0] v);
		ax(1'b1, 12'h404, {20'h0, a}, 1'b0);
		ax(1'b1, 12'h408, {24'h0, v}, 1'b0);
	endtask
	task automatic flashIs(input logic [11:0] a, input logic [7:0] v);
		ax(1'b1, 12'h404, {20'h0, a}, 1'b0);
		ax(1'b0, 12'h408, 32'h0, 1'b0);
		chk(q, {24'h0, v}, "flash byte");
	endtask
	task automatic call(input logic [7:0] c, b, p, input logic u, bad);
		core.svc(c, 8'h20, b, p, u, bad);
	endtask
	// bounded wait for the return pulse, then the first key byte
	task automatic done(input int lim, input logic [7:0] k1);
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (retValid !== 1'b1 && n < lim);
		chk(retValid, 1'b1, "no return pulse");
		ramIs(8'hF8, k1);
	endtask
	// three cycles of reset, then wait out the boot service
	task automatic rst();
		int n;
		@(posedge clk);
		nrst <= 1'b0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (svcBusy !== 1'b0 && n < 200);
		chk(svcBusy, 1'b0, "boot never ends");
	endtask
	// status after boot, refused accesses, ram top byte
	task automatic t_boot();
		ax(1'b0, 12'h400, 32'h0, 1'b0);
		chk(q, 32'h4, "status after boot");
		chk(svcState, ST_IDLE, "state after boot");
		chk(pready, 1'b1, "wait state inserted");
		ax(1'b1, 12'h404, 32'h1, 1'b1);
		ax(1'b0, 12'h408, 32'h0, 1'b1);
		ax(1'b0, 12'h410, 32'h0, 1'b1);
		ax(1'b1, 12'h3FC, 32'h5C, 1'b0);
		ramIs(8'hFF, 8'h5C);
		core.rom(1'b1);
	endtask
	// erase, write, read back block 1; neighbours untouched
	task automatic t_rw();
		call(8'h03, 8'h01, 8'h00, 1'b1, 1'b0);
		done(100, 8'h00);
		flashIs(12'h07F, 8'hFF);
		flashIs(12'h080, 8'h00);
		for (int i = 0; i < 64; i++)
			ax(1'b1, 12'h040 + 12'(i * 4), {24'h0, 8'(i) ^ 8'hA5}, 1'b0);
		call(8'h02, 8'h01, 8'h10, 1'b1, 1'b0);
		done(100, 8'h00);
		ramIs(8'hF9, 8'h00);
		chk(retAcc, 8'h00, "acc after write");
		chk(retSp, 8'h20, "sp after write");
		for (int i = 0; i < 64; i++)
			flashIs(12'h040 + 12'(i), 8'(i) ^ 8'hA5);
		flashIs(12'h03F, 8'h00);
		call(8'h01, 8'h01, 8'h60, 1'b1, 1'b0);
		done(100, 8'h00);
		for (int i = 0; i < 64; i++)
			ramIs(8'h60 + 8'(i), 8'(i) ^ 8'hA5);
	endtask
	// block 0 read-protected, block 1 write-protected and still readable
	task automatic t_prot();
		logic [7:0] cs [4] = '{8'h01, 8'h02, 8'h03, 8'h01};
		logic [7:0] bs [4] = '{8'h00, 8'h01, 8'h01, 8'h01};
		logic [7:0] rs [4] = '{8'h01, 8'h01, 8'h01, 8'h00};
		fput(12'h100, 8'h0D);
		for (int i = 0; i < 4; i++)
		begin
			call(cs[i], bs[i], 8'h60, 1'b1, 1'b0);
			done(100, rs[i]);
			ramIs(8'hF9, 8'h00);
			chk(retAcc, 8'h00, "acc after refusal");
		end
		flashIs(12'h040, 8'hA5);
	endtask
	// whole erase, table read, checksum and odd codes
	task automatic t_all();
		fput(12'h183, 8'h5A);
		call(8'h05, 8'h00, 8'h00, 1'b1, 1'b0);
		done(1200, 8'h00);
		flashIs(12'h000, 8'hFF);
		flashIs(12'h0C1, 8'hFF);
		flashIs(12'h100, 8'h00);
		flashIs(12'h183, 8'h5A);
		call(8'h06, 8'h03, 8'h00, 1'b1, 1'b0);
		done(50, 8'h5A);
		call(8'h07, 8'h00, 8'h00, 1'b1, 1'b0);
		done(200, 8'hC0);
		ramIs(8'hF9, 8'h3F);
		call(8'h01, 8'h04, 8'h60, 1'b1, 1'b0);
		done(50, 8'h03);
		call(8'h04, 8'h00, 8'h00, 1'b0, 1'b0);
		done(50, 8'h03);
		call(8'h00, 8'h00, 8'h00, 1'b1, 1'b1);
		done(200, 8'h02);
		chk(cpuHalt, 1'b0, "boot with bad key halted");
	endtask
	// bad key, then undefined user code: both halt until reset
	task automatic t_halt();
		for (int i = 0; i < 2; i++)
		begin
			call(i ? 8'h04 : 8'h01, 8'h00, 8'h60, 1'b1, i == 0);
			repeat (10) @(posedge clk);
			chk(cpuHalt, 1'b1, "no halt");
			chk(svcState, ST_HALT, "halt state");
			ax(1'b0, 12'h400, 32'h0, 1'b0);
			chk(q[1], 1'b1, "halt flag");
			rst();
			chk(cpuHalt, 1'b0, "halt after reset");
			core.rom(1'b1);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", samplesChecked, fails);
		if (fails == 0 && samplesChecked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial
	begin
		rst();
		t_boot();
		t_rw();
		t_prot();
		t_all();
		t_halt();
		tally_and_finish();
	end
	// watchdog: the run needs well under a tenth of this
	initial
	begin
		#400000;
		fails++;
		tally_and_finish();
	end
endmodule // tb_supervisory_flash_call
